// ==== hw/dsea_defines.svh ====
`ifndef DSEA_DEFINES_SVH
`define DSEA_DEFINES_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define DSEA_CLK_PERIOD_NS  100
`define DSEA_FILT_TIME_NS   800
`define DSEA_FILT_CYCLES \
  ((`DSEA_FILT_TIME_NS + `DSEA_CLK_PERIOD_NS - 1) / `DSEA_CLK_PERIOD_NS)
`define DSEA_RAW_CYCLES     2
`define DSEA_FILT_CNT_W     4

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define DSEA_OFF_CONFIG     8'h00
`define DSEA_OFF_COMMAND    8'h04
`define DSEA_OFF_SPLIT_LEN  8'h08
`define DSEA_OFF_SPLIT_WID  8'h0C
`define DSEA_OFF_SPLIT_CNT  8'h10
`define DSEA_OFF_DCC_WID    8'h14
`define DSEA_OFF_SYNC_WID   8'h18
`define DSEA_OFF_STATUS     8'h1C
`define DSEA_OFF_ERROR      8'h20
`define DSEA_OFF_IRQ_STAT   8'h24
`define DSEA_OFF_IRQ_MASK   8'h28

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DSEA_CFG_FUNC_LSB   0
`define DSEA_CFG_FUNC_MSB   1
`define DSEA_CFG_GP_OE      2
`define DSEA_CFG_GP_OUT     3
`define DSEA_CFG_FILT_EN    4
`define DSEA_CFG_SERVO_IN_POSITION_IN_EN   5
`define DSEA_CFG_DCC_AUTO   6
`define DSEA_CFG_SPLIT_NEG  7
`define DSEA_CFG_SPLIT_INIT 8
`define DSEA_CFG_SYNC_NEG   9
`define DSEA_CMD_DCC        0
`define DSEA_CMD_SPLIT_GO   1
`define DSEA_CMD_SPLIT_END  2
`define DSEA_CMD_SYNC       3
`define DSEA_CMD_ERR_CLR    4
`define DSEA_IRQ_EMG        0
`define DSEA_IRQ_SPLIT      1
`define DSEA_IRQ_TRIG       2
`define DSEA_IRQ_N          3
`define DSEA_FLT_EMG        0
`define DSEA_FLT_PIN        1
`define DSEA_FLT_SERVO_IN_POSITION_IN      2
`define DSEA_FLT_N          3

// ---------------------------------------------------------------
// Reset values and answers
// ---------------------------------------------------------------
`define DSEA_CONFIG_RST     32'h0000_0000
`define DSEA_SPLIT_LEN_RST  16'h000A
`define DSEA_SPLIT_WID_RST  16'h0005
`define DSEA_SPLIT_CNT_RST  16'h0000
`define DSEA_DCC_WID_RST    16'h000A
`define DSEA_SYNC_WID_RST   16'h000A
`define DSEA_FLT_RST        3'h1
`define DSEA_RESP_OKAY      2'h0
`define DSEA_RESP_SLVERR    2'h2

`endif

// ==== hw/dsea_filter.sv ====
`timescale 1ns/1ps
`include "dsea_defines.svh"

module dsea_filter
  import dsea_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   filterEn,
  input  wire logic [`DSEA_FLT_N-1:0] rawIn,
  output logic      [`DSEA_FLT_N-1:0] fltOut
);

  localparam logic [`DSEA_FILT_CNT_W-1:0] FiltLast =
    `DSEA_FILT_CNT_W'(`DSEA_FILT_CYCLES - 1);
  localparam logic [`DSEA_FILT_CNT_W-1:0] RawLast =
    `DSEA_FILT_CNT_W'(`DSEA_RAW_CYCLES - 1);

  dsea_flt_state_t s;
  dsea_flt_state_t n;
  logic [`DSEA_FILT_CNT_W-1:0] last;

  // ---------------------------------------------------------------
  // Per-input stability counter
  // ---------------------------------------------------------------
  always_comb begin
    n = s;
    n.smp = rawIn;
    // Short glitches never reach the block when the filter is on
    last = filterEn ? FiltLast : RawLast;
    for (int i = 0; i < `DSEA_FLT_N; i++) begin
      if (s.smp[i] == s.out[i]) begin
        n.cnt[i] = '0;
      end else if (s.cnt[i] >= last) begin
        n.out[i] = s.smp[i];
        n.cnt[i] = '0;
      end else begin
        n.cnt[i] = s.cnt[i] + `DSEA_FILT_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s     <= '0;
      s.smp <= `DSEA_FLT_RST;
      s.out <= `DSEA_FLT_RST;
    end else begin
      s <= n;
    end
  end

  assign fltOut = s.out;

endmodule

// ==== hw/dsea_pkg.sv ====
package dsea_pkg;
  `include "dsea_defines.svh"

  typedef enum logic [1:0] {
    DSEA_PIN_GPIO,
    DSEA_PIN_DRIVE,
    DSEA_PIN_SYNC_IN,
    DSEA_PIN_SYNC_OUT
  } dsea_pin_func_t;

  typedef enum logic {
    DSEA_SPLIT_IDLE,
    DSEA_SPLIT_RUN
  } dsea_split_t;

  typedef struct packed {
    logic [`DSEA_FLT_N-1:0]                        smp;
    logic [`DSEA_FLT_N-1:0][`DSEA_FILT_CNT_W-1:0]  cnt;
    logic [`DSEA_FLT_N-1:0]                        out;
  } dsea_flt_state_t;

  typedef struct packed {
    logic [31:0]            cfg;
    logic [15:0]            splitLen;
    logic [15:0]            splitWidth;
    logic [15:0]            splitCount;
    logic [15:0]            dccWidth;
    logic [15:0]            syncWidth;
    logic                   emgFlag;
    logic [`DSEA_IRQ_N-1:0] irqStat;
    logic [`DSEA_IRQ_N-1:0] irqMask;
    logic                   prevPulse;
    logic                   prevPin;
    logic                   inposWait;
    logic                   driveStat;
    logic [15:0]            dccCnt;
    logic [15:0]            syncCnt;
    dsea_split_t            splitSt;
    logic [15:0]            splitPhase;
    logic [15:0]            splitDone;
    logic                   splitSkip;
    logic                   awHave;
    logic                   wHave;
    logic [7:0]             awAddr;
    logic [31:0]            wData;
    logic [3:0]             wStrb;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic                   pinOut;
    logic                   pinOe;
    logic                   dccOut;
    logic                   splitOut;
    logic                   stopOut;
    logic                   errOut;
    logic                   trigOut;
    logic                   irqOut;
  } dsea_state_t;
endpackage

// ==== hw/dsea_top.sv ====
`timescale 1ns/1ps
`include "dsea_defines.svh"

// Summary of operation
// - One pin: GPIO bit zero or drive status
// - Drive status high while pulses emitted
// - Drive status high during home search
// - Optional hold until servo in-position
// - Emergency low while driving: stop, flag
// - Emergency input fixed active low
// - Selectable noise filter on filtered inputs
// - Deviation clear by home search or command
// - Split pulses started, stopped by trigger/command
// - Split interval, width, count programmable
// - Split polarity and initial pulse selectable
// - Pin as sync trigger in or pulse out
// - Error output high while error persists
module dsea_top
  import dsea_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        pulseActive,
  input  wire logic        homeSearchActive,
  input  wire logic        homeDccRequest,
  input  wire logic        splitSyncStart,
  input  wire logic        splitSyncStop,
  input  wire logic        syncPulseRequest,
  input  wire logic        emergencyStopN,
  input  wire logic        servoInPositionIn,
  input  wire logic        gpIoBitZeroIn,
  output logic             gpIoBitZeroOut,
  output logic             gpIoBitZeroOe,
  output logic             driveStopNow,
  output logic             errorStatusOut,
  output logic             deviationCounterClearOut,
  output logic             splitPulseOut,
  output logic             syncTriggerOut,
  output logic             irq
);

  dsea_state_t             s;
  dsea_state_t             n;
  logic [`DSEA_FLT_N-1:0]  fltOut;
  dsea_pin_func_t          func;
  logic                    emgLow;
  logic                    wrFire;
  logic [31:0]             wv;
  logic [31:0]             cmdBits;
  logic [`DSEA_IRQ_N-1:0]  w1c;
  logic [`DSEA_IRQ_N-1:0]  irqEv;
  logic                    splitGo;
  logic                    splitEnd;
  logic                    splitAct;
  logic                    syncAct;
  logic                    trig;
  logic [15:0]             doneNew;
  logic                    splitNeg;
  logic                    syncNeg;

  // ---------------------------------------------------------------
  // Address decode and read mux
  // ---------------------------------------------------------------
  function automatic logic isMapped(input logic [7:0] a);
    case (a)
      `DSEA_OFF_CONFIG, `DSEA_OFF_COMMAND, `DSEA_OFF_SPLIT_LEN,
      `DSEA_OFF_SPLIT_WID, `DSEA_OFF_SPLIT_CNT, `DSEA_OFF_DCC_WID,
      `DSEA_OFF_SYNC_WID, `DSEA_OFF_STATUS, `DSEA_OFF_ERROR,
      `DSEA_OFF_IRQ_STAT, `DSEA_OFF_IRQ_MASK: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] readReg(input dsea_state_t st,
                                          input logic [7:0]  a,
                                          input logic [2:0]  flt);
    readReg = '0;
    case (a)
      `DSEA_OFF_CONFIG:    readReg = st.cfg;
      `DSEA_OFF_SPLIT_LEN: readReg = {16'h0000, st.splitLen};
      `DSEA_OFF_SPLIT_WID: readReg = {16'h0000, st.splitWidth};
      `DSEA_OFF_SPLIT_CNT: readReg = {16'h0000, st.splitCount};
      `DSEA_OFF_DCC_WID:   readReg = {16'h0000, st.dccWidth};
      `DSEA_OFF_SYNC_WID:  readReg = {16'h0000, st.syncWidth};
      `DSEA_OFF_STATUS:    readReg = {26'h000_0000, st.dccOut,
                                      st.splitSt == DSEA_SPLIT_RUN,
                                      flt[`DSEA_FLT_SERVO_IN_POSITION_IN],
                                      flt[`DSEA_FLT_EMG],
                                      flt[`DSEA_FLT_PIN], st.driveStat};
      `DSEA_OFF_ERROR:     readReg = {31'h0000_0000, st.emgFlag};
      `DSEA_OFF_IRQ_STAT:  readReg = {29'h0000_0000, st.irqStat};
      `DSEA_OFF_IRQ_MASK:  readReg = {29'h0000_0000, st.irqMask};
      default:             readReg = '0;
    endcase
  endfunction

  function automatic logic [31:0] applyStrb(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  strb);
    applyStrb = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        applyStrb[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Input filters
  // ---------------------------------------------------------------
  dsea_filter u_filter (
    .clk      (clk),
    .rstn     (rstn),
    .filterEn (s.cfg[`DSEA_CFG_FILT_EN]),
    .rawIn    ({servoInPositionIn, gpIoBitZeroIn, emergencyStopN}),
    .fltOut   (fltOut)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n        = s;
    func     = dsea_pin_func_t'(s.cfg[`DSEA_CFG_FUNC_MSB:
                                      `DSEA_CFG_FUNC_LSB]);
    emgLow   = !fltOut[`DSEA_FLT_EMG];
    wrFire   = s.awHave && s.wHave && !s.bvalid;
    wv       = '0;
    cmdBits  = '0;
    w1c      = '0;
    irqEv    = '0;
    splitAct = 1'b0;
    doneNew  = s.splitDone;
    syncAct  = s.syncCnt != 16'h0000;
    trig     = 1'b0;

    // Bus write: address and data taken in either order
    if (s_axi_awvalid && s.awready) begin
      n.awHave = 1'b1;
      n.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      n.wHave = 1'b1;
      n.wData = s_axi_wdata;
      n.wStrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wrFire) begin
      n.awHave = 1'b0;
      n.wHave  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = isMapped(s.awAddr) ? `DSEA_RESP_OKAY
                                    : `DSEA_RESP_SLVERR;
      wv = applyStrb(readReg(s, s.awAddr, fltOut), s.wData, s.wStrb);
      case (s.awAddr)
        `DSEA_OFF_CONFIG:    n.cfg        = wv;
        `DSEA_OFF_COMMAND:   cmdBits      = wv;
        `DSEA_OFF_SPLIT_LEN: n.splitLen   = wv[15:0];
        `DSEA_OFF_SPLIT_WID: n.splitWidth = wv[15:0];
        `DSEA_OFF_SPLIT_CNT: n.splitCount = wv[15:0];
        `DSEA_OFF_DCC_WID:   n.dccWidth   = wv[15:0];
        `DSEA_OFF_SYNC_WID:  n.syncWidth  = wv[15:0];
        // Merged value would echo set bits, so clear from raw data
        `DSEA_OFF_IRQ_STAT:  w1c = s.wData[`DSEA_IRQ_N-1:0]
                                   & {`DSEA_IRQ_N{s.wStrb[0]}};
        `DSEA_OFF_IRQ_MASK:  n.irqMask = wv[`DSEA_IRQ_N-1:0];
        default: ;
      endcase
    end
    n.awready = !n.awHave && !n.bvalid;
    n.wready  = !n.wHave && !n.bvalid;

    // Bus read: one outstanding, data captured at address handshake
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rdata  = readReg(s, s_axi_araddr, fltOut);
      n.rresp  = isMapped(s_axi_araddr) ? `DSEA_RESP_OKAY
                                        : `DSEA_RESP_SLVERR;
    end
    n.arready = !n.rvalid;

    // Emergency stop: no deceleration, flag set wins over clear
    n.stopOut = emgLow;
    irqEv[`DSEA_IRQ_EMG] = emgLow && pulseActive;
    n.emgFlag = irqEv[`DSEA_IRQ_EMG]
                || (s.emgFlag && !cmdBits[`DSEA_CMD_ERR_CLR]);
    n.errOut  = n.emgFlag;

    // Drive status with optional in-position wait
    n.prevPulse = pulseActive;
    if (!s.cfg[`DSEA_CFG_SERVO_IN_POSITION_IN_EN] || fltOut[`DSEA_FLT_SERVO_IN_POSITION_IN]) begin
      n.inposWait = 1'b0;
    end else if (s.prevPulse && !pulseActive) begin
      n.inposWait = 1'b1;
    end
    n.driveStat = pulseActive || homeSearchActive
                  || n.inposWait;

    // Deviation counter clear, never shorter than one cycle
    if ((cmdBits[`DSEA_CMD_DCC] || (s.cfg[`DSEA_CFG_DCC_AUTO]
         && homeDccRequest)) && s.dccCnt == 16'h0000) begin
      n.dccCnt = (s.dccWidth == 16'h0000) ? 16'h0001 : s.dccWidth;
    end else if (s.dccCnt != 16'h0000) begin
      n.dccCnt = s.dccCnt - 16'h0001;
    end
    n.dccOut = n.dccCnt != 16'h0000;

    // Synchronous pulse out and trigger in on the shared pin
    if (cmdBits[`DSEA_CMD_SYNC] || syncPulseRequest) begin
      n.syncCnt = (s.syncWidth == 16'h0000) ? 16'h0001 : s.syncWidth;
    end else if (syncAct) begin
      n.syncCnt = s.syncCnt - 16'h0001;
    end
    n.prevPin = fltOut[`DSEA_FLT_PIN];
    trig = s.cfg[`DSEA_CFG_SYNC_NEG]
           ? (s.prevPin && !fltOut[`DSEA_FLT_PIN])
           : (!s.prevPin && fltOut[`DSEA_FLT_PIN]);
    n.trigOut = trig && func == DSEA_PIN_SYNC_IN;
    irqEv[`DSEA_IRQ_TRIG] = n.trigOut;

    // Pin function select
    case (func)
      DSEA_PIN_GPIO: begin
        n.pinOut = s.cfg[`DSEA_CFG_GP_OUT];
        n.pinOe  = s.cfg[`DSEA_CFG_GP_OE];
      end
      DSEA_PIN_DRIVE: begin
        n.pinOut = n.driveStat;
        n.pinOe  = 1'b1;
      end
      DSEA_PIN_SYNC_IN: begin
        n.pinOut = 1'b0;
        n.pinOe  = 1'b0;
      end
      DSEA_PIN_SYNC_OUT: begin
        n.pinOut = syncAct ^ s.cfg[`DSEA_CFG_SYNC_NEG];
        n.pinOe  = 1'b1;
      end
      default: begin
        n.pinOut = 1'b0;
        n.pinOe  = 1'b0;
      end
    endcase

    // Split pulse train; emergency also halts it
    splitGo  = cmdBits[`DSEA_CMD_SPLIT_GO] || splitSyncStart;
    splitEnd = cmdBits[`DSEA_CMD_SPLIT_END] || splitSyncStop
               || emgLow;
    case (s.splitSt)
      DSEA_SPLIT_IDLE: begin
        if (splitGo && !splitEnd) begin
          n.splitSt    = DSEA_SPLIT_RUN;
          n.splitPhase = '0;
          n.splitDone  = '0;
          n.splitSkip  = !s.cfg[`DSEA_CFG_SPLIT_INIT];
        end
      end
      DSEA_SPLIT_RUN: begin
        if (splitEnd) begin
          n.splitSt = DSEA_SPLIT_IDLE;
        end else begin
          splitAct = !s.splitSkip && s.splitPhase < s.splitWidth;
          if ({1'b0, s.splitPhase} + 17'h0_0001
              >= {1'b0, s.splitLen}) begin
            n.splitPhase = '0;
            n.splitSkip  = 1'b0;
            if (!s.splitSkip && s.splitWidth != 16'h0000) begin
              doneNew = s.splitDone + 16'h0001;
            end
            n.splitDone = doneNew;
            if (s.splitCount != 16'h0000
                && doneNew >= s.splitCount) begin
              n.splitSt = DSEA_SPLIT_IDLE;
              irqEv[`DSEA_IRQ_SPLIT] = 1'b1;
            end
          end else begin
            n.splitPhase = s.splitPhase + 16'h0001;
          end
        end
      end
      default: n.splitSt = DSEA_SPLIT_IDLE;
    endcase
    n.splitOut = splitAct ^ s.cfg[`DSEA_CFG_SPLIT_NEG];

    // Interrupts: an event in the clearing cycle survives
    n.irqStat = (s.irqStat & ~w1c) | irqEv;
    n.irqOut  = |(n.irqStat & n.irqMask);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s            <= '0;
      s.cfg        <= `DSEA_CONFIG_RST;
      s.splitLen   <= `DSEA_SPLIT_LEN_RST;
      s.splitWidth <= `DSEA_SPLIT_WID_RST;
      s.splitCount <= `DSEA_SPLIT_CNT_RST;
      s.dccWidth   <= `DSEA_DCC_WID_RST;
      s.syncWidth  <= `DSEA_SYNC_WID_RST;
    end else begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready            = s.awready;
  assign s_axi_wready             = s.wready;
  assign s_axi_bvalid             = s.bvalid;
  assign s_axi_bresp              = s.bresp;
  assign s_axi_arready            = s.arready;
  assign s_axi_rvalid             = s.rvalid;
  assign s_axi_rdata              = s.rdata;
  assign s_axi_rresp              = s.rresp;
  assign gpIoBitZeroOut           = s.pinOut;
  assign gpIoBitZeroOe            = s.pinOe;
  assign driveStopNow             = s.stopOut;
  assign errorStatusOut           = s.errOut;
  assign deviationCounterClearOut = s.dccOut;
  assign splitPulseOut            = s.splitOut;
  assign syncTriggerOut           = s.trigOut;
  assign irq                      = s.irqOut;
  assign splitNeg                 = s.cfg[`DSEA_CFG_SPLIT_NEG];
  assign syncNeg                  = s.cfg[`DSEA_CFG_SYNC_NEG];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_pin_drive_mux: assert property (
    func == DSEA_PIN_DRIVE |=> gpIoBitZeroOe)
    else $error("drive function did not enable pin");
  chk_drive_pulses: assert property (
    func == DSEA_PIN_DRIVE && pulseActive |=> gpIoBitZeroOut)
    else $error("drive status low while pulsing");
  chk_drive_home: assert property (
    func == DSEA_PIN_DRIVE && homeSearchActive |=> gpIoBitZeroOut)
    else $error("drive status low during home search");
  chk_servo_in_position_in_hold: assert property (
    s.cfg[`DSEA_CFG_SERVO_IN_POSITION_IN_EN] && $fell(pulseActive)
    && !fltOut[`DSEA_FLT_SERVO_IN_POSITION_IN] |=> s.driveStat ##1 s.driveStat)
    else $error("drive status dropped before in-position");
  chk_emg_stop: assert property (
    pulseActive && !fltOut[`DSEA_FLT_EMG]
    |=> driveStopNow && s.emgFlag ##1 errorStatusOut)
    else $error("emergency did not stop and flag");
  chk_emg_fixed: assert property (
    fltOut[`DSEA_FLT_EMG] |=> !driveStopNow)
    else $error("stop asserted with emergency input high");
  chk_dcc_pulse: assert property (
    s.dccCnt > 16'h0001 |=> deviationCounterClearOut)
    else $error("deviation clear ended early");
  chk_split_stop: assert property (
    s.splitSt == DSEA_SPLIT_RUN && splitSyncStop
    |=> s.splitSt == DSEA_SPLIT_IDLE ##1 splitPulseOut == $past(splitNeg))
    else $error("split train did not stop");
  chk_split_count: assert property (
    s.splitSt == DSEA_SPLIT_RUN && s.splitCount != 16'h0000
    |-> s.splitDone < s.splitCount)
    else $error("split count exceeded");
  chk_split_idle_lvl: assert property (
    s.splitSt == DSEA_SPLIT_IDLE |=> splitPulseOut == $past(splitNeg))
    else $error("split idle level wrong");
  chk_sync_pulse_out: assert property (
    func == DSEA_PIN_SYNC_OUT && syncAct
    |=> gpIoBitZeroOe && gpIoBitZeroOut != $past(syncNeg))
    else $error("sync pulse not driven at level");
  chk_error_out: assert property (
    s.emgFlag |-> errorStatusOut)
    else $error("error output low with error set");
  chk_drive_idle: assert property (
    func == DSEA_PIN_DRIVE && !pulseActive && !homeSearchActive
    && !n.inposWait |=> !gpIoBitZeroOut)
    else $error("drive status high while idle");

endmodule

// ==== tb/dsea_partner.sv ====
`timescale 1ns/1ps
// ---
// Servo driver and field equipment
// ---
module dsea_partner (
  input  wire logic        clk,
  input  wire logic        emgReq,
  input  wire logic        inposLevel,
  input  wire logic        cntClr,
  input  wire logic        gpIoBitZeroOut,
  input  wire logic        gpIoBitZeroOe,
  input  wire logic        deviationCounterClearOut,
  input  wire logic        splitPulseOut,
  output logic             emergencyStopN,
  output logic             servoInPositionIn,
  output logic             gpIoBitZeroIn,
  output logic [15:0]      dccCycles,
  output logic [15:0]      splitEdges
);
  logic [1:0] hold = 2'h0;
  logic       splitPrev;
  // Stretched past two clocks
  assign emergencyStopN = !(emgReq || hold != 2'h0);
  assign servoInPositionIn = inposLevel;
  // Released pin: pull-up
  assign gpIoBitZeroIn = gpIoBitZeroOe ? gpIoBitZeroOut : 1'b1;
  always @(posedge clk) begin
    if (emgReq) hold <= 2'h3;
    else if (hold != 2'h0) hold <= hold - 2'h1;
    splitPrev <= splitPulseOut;
    if (cntClr) begin
      dccCycles <= 16'h0000;
      splitEdges <= 16'h0000;
    end else begin
      if (deviationCounterClearOut) dccCycles <= dccCycles + 16'h0001;
      if (splitPulseOut && !splitPrev) splitEdges <= splitEdges + 16'h0001;
    end
  end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "dsea_defines.svh"
module testbench
  import dsea_pkg::*;
;
  logic        clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, pulseActive;
  logic        homeSearchActive, homeDccRequest, splitSyncStart;
  logic        splitSyncStop, syncPulseRequest, emergencyStopN;
  logic        servoInPositionIn, gpIoBitZeroIn, gpIoBitZeroOut;
  logic        gpIoBitZeroOe, driveStopNow, errorStatusOut, irq;
  logic        deviationCounterClearOut, splitPulseOut, syncTriggerOut;
  logic        emgReq, inposLevel, cntClr;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [15:0] dccCycles, splitEdges;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdVal;
  int          n_mismatch, cmp_count, cycles;

  dsea_top i_dsea_top (.*);
  dsea_partner i_dsea_partner (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      final_report();
    end
  end
  // -------------
  // Shared tasks
  // -------------
  task automatic final_report;
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [31:0] pin();
    return {30'h0, gpIoBitZeroOe, gpIoBitZeroOut};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdVal = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic clr;
    cntClr <= 1'b1;
    cyc(3);
    cntClr <= 1'b0;
  endtask
  // ---------
  // Scenarios
  // ---------
  task automatic t_regs;
    rd(`DSEA_OFF_SPLIT_LEN);
    chk("splitLenRst", 32'h0000_000A, rdVal);
    rd(8'h40);
    chk("unmappedResp", {30'h0, `DSEA_RESP_SLVERR}, {30'h0, rsp});
  endtask
  task automatic t_drive;
    wr(`DSEA_OFF_CONFIG, 32'h0000_000C);
    cyc(3);
    chk("gpioMode", 32'h3, pin());
    wr(`DSEA_OFF_CONFIG, 32'h0000_0001);
    cyc(3);
    chk("idle", 32'h2, pin());
    pulseActive <= 1'b1;
    cyc(3);
    chk("driving", 32'h3, pin());
    pulseActive <= 1'b0;
    homeSearchActive <= 1'b1;
    cyc(3);
    chk("homing", 32'h3, pin());
    homeSearchActive <= 1'b0;
    cyc(3);
    chk("idleAgain", 32'h2, pin());
    wr(`DSEA_OFF_CONFIG, 32'h0000_0021);
    pulseActive <= 1'b1;
    cyc(2);
    pulseActive <= 1'b0;
    cyc(12);
    chk("inposWait", 32'h3, pin());
    inposLevel <= 1'b1;
    cyc(6);
    chk("inposDone", 32'h2, pin());
    wr(`DSEA_OFF_CONFIG, 32'h0000_0002);
    cyc(6);
    rd(`DSEA_OFF_IRQ_STAT);
    chk("trig", 32'h4, rdVal);
    wr(`DSEA_OFF_CONFIG, 32'h0000_0003);
    syncPulseRequest <= 1'b1;
    cyc(3);
    chk("sync", 32'h3, pin());
    syncPulseRequest <= 1'b0;
  endtask
  task automatic t_emg;
    wr(`DSEA_OFF_CONFIG, 32'h0000_0010);
    wr(`DSEA_OFF_IRQ_MASK, 32'h0000_0001);
    pulseActive <= 1'b1;
    emgReq <= 1'b1;
    cyc(1);
    emgReq <= 1'b0;
    cyc(12);
    chk("shortIgnored", 32'h0, {31'h0, driveStopNow});
    wr(`DSEA_OFF_CONFIG, 32'h0000_0000);
    emgReq <= 1'b1;
    cyc(6);
    chk("stopErr", 32'h7, {29'h0, driveStopNow, errorStatusOut, irq});
    rd(`DSEA_OFF_ERROR);
    chk("errorReg", 32'h1, rdVal);
    emgReq <= 1'b0;
    pulseActive <= 1'b0;
    wr(`DSEA_OFF_IRQ_MASK, 32'h0000_0000);
    cyc(8);
    chk("errHeldMasked", 32'h2, {30'h0, errorStatusOut, irq});
    wr(`DSEA_OFF_IRQ_STAT, 32'h0000_0001);
    wr(`DSEA_OFF_COMMAND, 32'h0000_0010);
    cyc(2);
    chk("errCleared", 32'h0, {31'h0, errorStatusOut});
  endtask
  task automatic t_dcc;
    wr(`DSEA_OFF_DCC_WID, 32'h0000_0003);
    clr();
    wr(`DSEA_OFF_COMMAND, 32'h0000_0001);
    cyc(8);
    chk("dccCmd", 32'h3, {16'h0, dccCycles});
    wr(`DSEA_OFF_CONFIG, 32'h0000_0040);
    clr();
    homeSearchActive <= 1'b1;
    homeDccRequest <= 1'b1;
    cyc(1);
    homeDccRequest <= 1'b0;
    cyc(8);
    homeSearchActive <= 1'b0;
    chk("dccHome", 32'h3, {16'h0, dccCycles});
  endtask
  task automatic t_split;
    wr(`DSEA_OFF_SPLIT_LEN, 32'h0000_0004);
    wr(`DSEA_OFF_SPLIT_WID, 32'h0000_0002);
    wr(`DSEA_OFF_SPLIT_CNT, 32'h0000_0003);
    wr(`DSEA_OFF_CONFIG, 32'h0000_0100);
    clr();
    wr(`DSEA_OFF_COMMAND, 32'h0000_0002);
    cyc(30);
    chk("splitCmd", 32'h3, {16'h0, splitEdges});
    rd(`DSEA_OFF_IRQ_STAT);
    chk("splitIrq", 32'h2, rdVal & 32'h2);
    wr(`DSEA_OFF_SPLIT_CNT, 32'h0000_0002);
    wr(`DSEA_OFF_CONFIG, 32'h0000_0080);
    clr();
    splitSyncStart <= 1'b1;
    cyc(1);
    splitSyncStart <= 1'b0;
    cyc(30);
    chk("splitLow", 32'h2, {16'h0, splitEdges});
    chk("splitIdle", 32'h1, {31'h0, splitPulseOut});
    wr(`DSEA_OFF_SPLIT_CNT, 32'h0000_0000);
    wr(`DSEA_OFF_CONFIG, 32'h0000_0000);
    wr(`DSEA_OFF_COMMAND, 32'h0000_0002);
    cyc(10);
    splitSyncStop <= 1'b1;
    cyc(1);
    splitSyncStop <= 1'b0;
    clr();
    cyc(20);
    chk("splitStopped", 32'h0, {16'h0, splitEdges});
  endtask

  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, pulseActive, homeSearchActive, homeDccRequest} = '0;
    {splitSyncStart, splitSyncStop, syncPulseRequest, emgReq} = '0;
    {inposLevel, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    cntClr = 1'b1;
    cyc(16);
    rstn <= 1'b1;
    cyc(2);
    t_regs();
    t_drive();
    t_emg();
    t_dcc();
    t_split();
    final_report();
  end
endmodule
